// >>> design/omt16_timer.sv
// What this block does
// - One-shot mode raises a single interrupt when the down-counter underflows.
// - One-shot start comes from the enable bit or from a preceding-timer overflow.
// - One timer tick after a one-shot start, hardware clears the enable bit.
// - One-shot always loads from reload and counts down; reload control ignored.
// - One-shot counter stops on underflow and whenever timer reset is asserted.
// - One-shot in event mode uses preceding-timer overflows as the counting tick.
// - Output pin goes active when one-shot counting starts, inactive when it stops.
// - Timer reset loads new reload value at once; otherwise loaded at underflow.
// - Reading the count register in one-shot mode returns the live count.
// - Measurement interrupts after each measurement and on overflow.
// - Measurement counts up from zero in timer clocks, up to all ones.
// - At each effective edge after the first: copy count to reload, clear counter, keep counting.
// - Measurement starts with enable; stops on reset, overflow or enable cleared.
// - First effective edge after start begins counting without an interrupt.
// - Overflow before any completed measurement makes reload read zero.
// - In measurement mode the reload register is read-only to firmware.
// - After enable, measurement begins at the next qualifying input edge.
// - Pulse-width overflow writes zero into reload and clears enable.
// - Pulse-width gives no interrupt until a rising and a falling edge are seen.
// - Period mode interrupts only after two edges of the same polarity.
// - Output polarity bit set to one makes the one-shot pulse active low.
`include "omt16_defines.svh"

module omt16_timer
    import omt16_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Timer pins and chaining
    input  wire logic        timerInputPin,
    input  wire logic        chainOverflow,
    output logic             timerOutputPin,
    output logic             irqRequest
);

    // =================================================================
    // Declarations
    omt_ctrl_s   ctrl;
    omt_cfg_s    cfg;
    omt_state_e  state;
    omt_state_e  next_state;
    logic [15:0] reload;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [3:0]  presc;
    logic        prescTick;
    logic        timerTick;
    logic        inLevel;
    logic        inPrev;
    logic        effRise;
    logic        effFall;
    logic        effEdge;
    logic        seenRise;
    logic        seenFall;
    logic        clrPending;
    logic        startNow;
    logic        underflow;
    logic        overflow;
    logic        capture;
    logic        measIrq;
    logic        hwClrEnable;
    logic        addrPhase;
    logic        wrPend;
    logic [11:0] wrAddr;
    logic [31:0] rdWord;

    // =================================================================
    // Input pin synchroniser
    omt16_sync u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .asyncIn (timerInputPin),
        .syncOut (inLevel)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inPrev <= 1'b0;
        end else begin
            inPrev <= inLevel;
        end
    end

    assign effRise = inLevel & ~inPrev & cfg.edgeRise;
    assign effFall = ~inLevel & inPrev & cfg.edgeFall;
    assign effEdge = effRise | effFall;

    // =================================================================
    // Timer clock: prescaler, or chained overflow in event mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= `OMT_DIV_ZERO;
        end else if (prescTick) begin
            presc <= `OMT_DIV_ZERO;
        end else begin
            presc <= presc + `OMT_DIV_ONE;
        end
    end

    assign prescTick = (presc == cfg.divider);
    // Chained ticks are same-clock logic, so they need no synchroniser
    assign timerTick = (cfg.mode == MODE_ONESHOT && cfg.eventTick) ? chainOverflow
                                                                   : prescTick;

    // =================================================================
    // Timer core next state
    always_comb begin
        next_state = state;
        next_count = count;
        startNow   = 1'b0;
        underflow  = 1'b0;
        overflow   = 1'b0;
        capture    = 1'b0;
        measIrq    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (!ctrl.timerReset && ctrl.enable) begin
                    if (cfg.mode == MODE_ONESHOT) begin
                        if (!cfg.startChain || chainOverflow) begin
                            next_state = ST_RUN;
                            next_count = reload;
                            startNow   = 1'b1;
                        end
                    end else begin
                        next_state = ST_WAIT;
                        next_count = `OMT_COUNT_ZERO;
                    end
                end
            end
            ST_RUN: begin
                if (timerTick) begin
                    if (count == `OMT_COUNT_ZERO) begin
                        underflow  = 1'b1;
                        next_state = ST_IDLE;
                        next_count = reload;
                    end else begin
                        next_count = count - `OMT_COUNT_ONE;
                    end
                end
            end
            ST_WAIT: begin
                if (!ctrl.enable) begin
                    next_state = ST_IDLE;
                end else if (effEdge) begin
                    next_state = ST_MEAS;
                    next_count = `OMT_COUNT_ZERO;
                end
            end
            ST_MEAS: begin
                if (!ctrl.enable) begin
                    next_state = ST_IDLE;
                end else if (effEdge) begin
                    capture    = 1'b1;
                    next_count = `OMT_COUNT_ZERO;
                    if (cfg.periodSel) begin
                        measIrq = (effRise && seenRise) || (effFall && seenFall);
                    end else begin
                        measIrq = (effRise && seenFall) || (effFall && seenRise);
                    end
                end else if (timerTick) begin
                    if (count == `OMT_COUNT_MAX) begin
                        overflow   = 1'b1;
                        next_state = ST_IDLE;
                        next_count = `OMT_COUNT_ZERO;
                    end else begin
                        next_count = count + `OMT_COUNT_ONE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (ctrl.timerReset) begin
            next_state = ST_IDLE;
            next_count = (cfg.mode == MODE_ONESHOT) ? reload : `OMT_COUNT_ZERO;
        end
    end

    // =================================================================
    // State and counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `OMT_COUNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // =================================================================
    // Edge history since the measurement start
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seenRise <= 1'b0;
            seenFall <= 1'b0;
        end else if (next_state == ST_WAIT || next_state == ST_MEAS) begin
            seenRise <= seenRise | effRise;
            seenFall <= seenFall | effFall;
        end else begin
            seenRise <= 1'b0;
            seenFall <= 1'b0;
        end
    end

    // =================================================================
    // Enable self-clear, one timer tick after a one-shot start or on measurement overflow
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clrPending <= 1'b0;
        end else if (startNow) begin
            clrPending <= 1'b1;
        end else if (timerTick || ctrl.timerReset) begin
            clrPending <= 1'b0;
        end
    end

    assign hwClrEnable = (clrPending && timerTick) || overflow;

    // =================================================================
    // Outputs toward the system
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= underflow || overflow || measIrq;
        end
    end

    // Pin is driven every cycle so a polarity change shows at once when idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timerOutputPin <= 1'b0;
        end else begin
            timerOutputPin <= ((next_state == ST_RUN) && ctrl.outEnable)
                              ^ ctrl.outPolarity;
        end
    end

    // =================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign addrPhase = hsel && hready && htrans[`OMT_HTRANS_ACT_BIT];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrAddr <= `OMT_OFS_CTRL;
        end else begin
            wrPend <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr <= haddr[11:0];
            end
        end
    end

    always_comb begin
        rdWord = `OMT_WORD_ZERO;
        case (haddr[11:0])
            `OMT_OFS_CTRL: begin
                rdWord[`OMT_CTRL_ENABLE]   = ctrl.enable;
                rdWord[`OMT_CTRL_RESET]    = ctrl.timerReset;
                rdWord[`OMT_CTRL_OUT_EN]   = ctrl.outEnable;
                rdWord[`OMT_CTRL_RLD_CTRL] = ctrl.reloadControl;
                rdWord[`OMT_CTRL_POLARITY] = ctrl.outPolarity;
            end
            `OMT_OFS_CFG: begin
                rdWord[`OMT_CFG_MODE]                     = cfg.mode;
                rdWord[`OMT_CFG_PERIOD]                   = cfg.periodSel;
                rdWord[`OMT_CFG_EDGE_RISE]                = cfg.edgeRise;
                rdWord[`OMT_CFG_EDGE_FALL]                = cfg.edgeFall;
                rdWord[`OMT_CFG_START_CHAIN]              = cfg.startChain;
                rdWord[`OMT_CFG_EVENT_TICK]               = cfg.eventTick;
                rdWord[`OMT_CFG_DIV_HI:`OMT_CFG_DIV_LO]   = cfg.divider;
            end
            `OMT_OFS_RELOAD: begin
                rdWord[15:0] = reload;
            end
            `OMT_OFS_COUNT: begin
                rdWord[15:0] = count;
            end
            default: begin
                rdWord = `OMT_WORD_ZERO;
            end
        endcase
    end

    // Sampled in the address phase; the data phase carries it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= `OMT_WORD_ZERO;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdWord;
        end
    end

    // =================================================================
    // Control register; a firmware write wins over the hardware clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else if (wrPend && wrAddr == `OMT_OFS_CTRL) begin
            ctrl.enable        <= hwdata[`OMT_CTRL_ENABLE];
            ctrl.timerReset    <= hwdata[`OMT_CTRL_RESET];
            ctrl.outEnable     <= hwdata[`OMT_CTRL_OUT_EN];
            ctrl.reloadControl <= hwdata[`OMT_CTRL_RLD_CTRL];
            ctrl.outPolarity   <= hwdata[`OMT_CTRL_POLARITY];
        end else if (hwClrEnable) begin
            ctrl.enable <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '0;
        end else if (wrPend && wrAddr == `OMT_OFS_CFG) begin
            cfg.mode       <= omt_mode_e'(hwdata[`OMT_CFG_MODE]);
            cfg.periodSel  <= hwdata[`OMT_CFG_PERIOD];
            cfg.edgeRise   <= hwdata[`OMT_CFG_EDGE_RISE];
            cfg.edgeFall   <= hwdata[`OMT_CFG_EDGE_FALL];
            cfg.startChain <= hwdata[`OMT_CFG_START_CHAIN];
            cfg.eventTick  <= hwdata[`OMT_CFG_EVENT_TICK];
            cfg.divider    <= hwdata[`OMT_CFG_DIV_HI:`OMT_CFG_DIV_LO];
        end
    end

    // =================================================================
    // Reload register: firmware in one-shot, hardware in measurement
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload <= `OMT_RELOAD_RST;
        end else if (capture) begin
            reload <= count;
        end else if (overflow) begin
            reload <= `OMT_COUNT_ZERO;
        end else if (wrPend && wrAddr == `OMT_OFS_RELOAD && cfg.mode == MODE_ONESHOT) begin
            reload <= hwdata[15:0];
        end
    end

endmodule : omt16_timer

// >>> design/omt16_defines.svh
`ifndef OMT16_DEFINES_SVH
`define OMT16_DEFINES_SVH

// =====================================================================
// Register byte offsets (decoded on haddr[11:0])
`define OMT_OFS_CTRL        12'h000
`define OMT_OFS_CFG         12'h004
`define OMT_OFS_RELOAD      12'h008
`define OMT_OFS_COUNT       12'h00C

// =====================================================================
// Control register fields
`define OMT_CTRL_ENABLE     0
`define OMT_CTRL_RESET      1
`define OMT_CTRL_OUT_EN     6
`define OMT_CTRL_RLD_CTRL   7
`define OMT_CTRL_POLARITY   10

// =====================================================================
// Clock and event configuration fields
`define OMT_CFG_MODE        0
`define OMT_CFG_PERIOD      1
`define OMT_CFG_EDGE_RISE   2
`define OMT_CFG_EDGE_FALL   3
`define OMT_CFG_START_CHAIN 4
`define OMT_CFG_EVENT_TICK  5
`define OMT_CFG_DIV_LO      8
`define OMT_CFG_DIV_HI      11

// =====================================================================
// Values
`define OMT_COUNT_ZERO      16'h0000
`define OMT_COUNT_MAX       16'hFFFF
`define OMT_COUNT_ONE       16'h0001
`define OMT_RELOAD_RST      16'h0000
`define OMT_DIV_ZERO        4'h0
`define OMT_DIV_ONE         4'h1
`define OMT_WORD_ZERO       32'h0000_0000
`define OMT_HTRANS_ACT_BIT  1

`endif

// >>> design/omt16_pkg.sv
package omt16_pkg;

    // =================================================================
    // Modes and states
    typedef enum logic {
        MODE_ONESHOT = 1'b0,
        MODE_MEASURE = 1'b1
    } omt_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_WAIT = 2'b10,
        ST_MEAS = 2'b11
    } omt_state_e;

    // =================================================================
    // Register carriers
    typedef struct packed {
        logic outPolarity;
        logic reloadControl;
        logic outEnable;
        logic timerReset;
        logic enable;
    } omt_ctrl_s;

    typedef struct packed {
        logic [3:0] divider;
        logic       eventTick;
        logic       startChain;
        logic       edgeFall;
        logic       edgeRise;
        logic       periodSel;
        omt_mode_e  mode;
    } omt_cfg_s;

endpackage : omt16_pkg

// >>> design/omt16_sync.sv
module omt16_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Asynchronous level in, filtered level out
    input  wire logic asyncIn,
    output logic      syncOut
);

    logic stage1;
    logic stage2;
    logic stage3;

    // =================================================================
    // Three-stage capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // =================================================================
    // A change counts only once the last two stages agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncOut <= 1'b0;
        end else if (stage2 == stage3) begin
            syncOut <= stage3;
        end
    end

endmodule : omt16_sync

// >>> tb/omt16_far_end.sv
module omt16_far_end (
    // Clock
    input  wire logic sys_clk,
    // Pins toward the timer
    output logic      timerInputPin,
    output logic      chainOverflow
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        timerInputPin = 1'b0;
        chainOverflow = 1'b0;
    end

    // Async source: change off the sampling edge
    task automatic setPin(input logic lvl);
        @(negedge sys_clk);
        timerInputPin = lvl;
    endtask : setPin

    // Preceding timer overflow is one cycle
    task automatic chainPulse();
        @(posedge sys_clk);
        chainOverflow <= 1'b1;
        @(posedge sys_clk);
        chainOverflow <= 1'b0;
    endtask : chainPulse
endmodule : omt16_far_end

// >>> tb/omt16_timer_props.sv
module omt16_timer_props (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Timer pins
    input wire logic        timerInputPin,
    input wire logic        chainOverflow,
    input wire logic        timerOutputPin,
    input wire logic        irqRequest
);
    // ==============================================================
    // Control shadow; polarity lags like the pin
    logic        wrPend;
    logic [11:0] wrAddr;
    logic [31:0] ctrlW;
    logic [31:0] cfgW;
    logic        pinAct;
    logic        oneShot;
    logic        outEn;
    logic        polDly;

    assign pinAct  = timerOutputPin != polDly;
    assign oneShot = !cfgW[0];
    assign outEn   = ctrlW[6];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 12'h000;
            ctrlW  <= 32'h0000_0000;
            cfgW   <= 32'h0000_0000;
            polDly <= 1'b0;
        end else begin
            wrPend <= hsel && hready && htrans[1] && hwrite;
            wrAddr <= haddr[11:0];
            polDly <= ctrlW[10];
            if (wrPend && wrAddr == 12'h000) ctrlW <= hwdata;
            if (wrPend && wrAddr == 12'h004) cfgW <= hwdata;
        end
    end

    // ==============================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_runEnd;
        pinAct ##1 !pinAct;
    endsequence
    property p_irqPulse;
        irqRequest |=> !irqRequest;
    endproperty
    property p_stopIrq;
        s_runEnd ##0 (oneShot && outEn && !ctrlW[1]) |-> ##[0:1] irqRequest;
    endproperty
    property p_irqAtStop;
        oneShot && outEn && $rose(irqRequest) |-> !pinAct && ($past(pinAct) || $past(pinAct, 2));
    endproperty
    property p_chainStart;
        oneShot && outEn && cfgW[4] && $rose(pinAct) |-> $past(chainOverflow);
    endproperty
    property p_resetStops;
        ctrlW[1] [*3] ##0 (oneShot && outEn) |-> !pinAct;
    endproperty
    property p_ready;
        hreadyout;
    endproperty
    property p_okay;
        !hresp;
    endproperty
    property p_hold;
        !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata);
    endproperty
    property p_rstQuiet;
        $rose(rst_n) |-> !irqRequest && !timerOutputPin;
    endproperty
    a_irqPulse: assert property (p_irqPulse) else $error("irq too long");
    a_stopIrq: assert property (p_stopIrq) else $error("no irq at run end");
    a_irqAtStop: assert property (p_irqAtStop) else $error("irq without run end");
    a_chainStart: assert property (p_chainStart) else $error("start without chain");
    a_resetStops: assert property (p_resetStops) else $error("pin active in reset");
    a_ready: assert property (p_ready) else $error("wait state seen");
    a_okay: assert property (p_okay) else $error("error response seen");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_rstQuiet: assert property (p_rstQuiet) else $error("busy after reset");
endmodule : omt16_timer_props

bind omt16_timer omt16_timer_props i_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .timerInputPin(timerInputPin), .chainOverflow(chainOverflow),
    .timerOutputPin(timerOutputPin), .irqRequest(irqRequest)
);

// >>> tb/tb_oneshot_measure_timer16.sv
module tb_oneshot_measure_timer16;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        timerInputPin;
    logic        chainOverflow;
    logic        timerOutputPin;
    logic        irqRequest;
    logic [31:0] q;
    logic [31:0] q2;
    int          n_errors = 0;
    int          n_checks = 0;
    int          irqCnt = 0;
    int          actCnt = 0;
    int          irq0;

    assign hready = hreadyout;

    omt16_timer i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .timerInputPin(timerInputPin), .chainOverflow(chainOverflow),
        .timerOutputPin(timerOutputPin), .irqRequest(irqRequest)
    );
    omt16_far_end i_far (
        .sys_clk(sys_clk), .timerInputPin(timerInputPin), .chainOverflow(chainOverflow)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (irqRequest === 1'b1) irqCnt++;
        if (timerOutputPin === 1'b1) actCnt++;
    end

    // ==============================================================
    // Bus and check tasks
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        haddr  <= {20'h0_0000, a};
        do @(posedge sys_clk); while (!hready);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (!hready);
        q = hrdata;
    endtask : xfer

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t ns: expected %h, got %h", $time, e, g);
        end
    endtask : chk

    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(e, q);
    endtask : rdChk

    task automatic waitIrq(input int n);
        for (int i = 0; i < n && irqCnt == irq0; i++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
    endtask : waitIrq

    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end

    // ==============================================================
    // Tests
    initial begin
        rst_n  = 1'b0;
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b000;
        hwdata = 32'h0000_0000;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 16; a += 4) rdChk(a[11:0], 32'h0);
        xfer(1'b1, 12'h010, 32'hFFFF_FFFF);
        rdChk(12'h010, 32'h0);
        // Plain one-shot, reload control set but ignored
        xfer(1'b1, 12'h008, 32'h3);
        irq0   = irqCnt;
        actCnt = 0;
        xfer(1'b1, 12'h000, 32'hC1);
        repeat (10) @(posedge sys_clk);
        rdChk(12'h000, 32'hC0);
        chk(32'h4, 32'(actCnt));
        chk(32'h1, 32'(irqCnt - irq0));
        rdChk(12'h00C, 32'h3);
        // Active-low pulse, live count, timer reset
        xfer(1'b1, 12'h008, 32'h100);
        irq0 = irqCnt;
        xfer(1'b1, 12'h000, 32'h441);
        repeat (3) @(posedge sys_clk);
        chk(32'h0, {31'h0, timerOutputPin});
        xfer(1'b0, 12'h00C, 32'h0);
        q2 = q;
        xfer(1'b0, 12'h00C, 32'h0);
        chk(32'h1, {31'h0, q < q2});
        xfer(1'b1, 12'h000, 32'h442);
        rdChk(12'h00C, 32'h100);
        chk(32'h1, {31'h0, timerOutputPin});
        xfer(1'b1, 12'h008, 32'h20);
        rdChk(12'h00C, 32'h20);
        chk(32'h0, 32'(irqCnt - irq0));
        xfer(1'b1, 12'h000, 32'h0);
        // Reload taken at underflow without reset
        xfer(1'b1, 12'h008, 32'h10);
        irq0 = irqCnt;
        xfer(1'b1, 12'h000, 32'h41);
        xfer(1'b1, 12'h008, 32'h7);
        waitIrq(100);
        rdChk(12'h00C, 32'h7);
        // Chain start and ticks
        xfer(1'b1, 12'h004, 32'h30);
        xfer(1'b1, 12'h008, 32'h2);
        irq0 = irqCnt;
        i_far.chainPulse();
        repeat (3) @(posedge sys_clk);
        chk(32'h0, {31'h0, timerOutputPin});
        xfer(1'b1, 12'h000, 32'h41);
        repeat (5) @(posedge sys_clk);
        chk(32'h0, {31'h0, timerOutputPin});
        i_far.chainPulse();
        repeat (2) @(posedge sys_clk);
        chk(32'h1, {31'h0, timerOutputPin});
        rdChk(12'h00C, 32'h2);
        i_far.chainPulse();
        rdChk(12'h00C, 32'h1);
        rdChk(12'h000, 32'h40);
        i_far.chainPulse();
        i_far.chainPulse();
        waitIrq(10);
        chk(32'h1, 32'(irqCnt - irq0));
        chk(32'h0, {31'h0, timerOutputPin});
        // Pulse width measurement
        xfer(1'b1, 12'h004, 32'hD);
        xfer(1'b1, 12'h008, 32'h55);
        rdChk(12'h008, 32'h2);
        irq0 = irqCnt;
        xfer(1'b1, 12'h000, 32'h1);
        repeat (20) @(posedge sys_clk);
        chk(32'h0, 32'(irqCnt - irq0));
        i_far.setPin(1'b1);
        repeat (10) @(posedge sys_clk);
        chk(32'h0, 32'(irqCnt - irq0));
        repeat (40) @(posedge sys_clk);
        i_far.setPin(1'b0);
        repeat (10) @(posedge sys_clk);
        chk(32'h1, 32'(irqCnt - irq0));
        xfer(1'b0, 12'h008, 32'h0);
        chk(32'h1, {31'h0, q >= 48 && q <= 51});
        xfer(1'b0, 12'h00C, 32'h0);
        chk(32'h1, {31'h0, q >= 5 && q <= 40});
        // Period measurement on rising edges
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b1, 12'h004, 32'h7);
        xfer(1'b1, 12'h000, 32'h1);
        irq0 = irqCnt;
        i_far.setPin(1'b1);
        repeat (30) @(posedge sys_clk);
        i_far.setPin(1'b0);
        repeat (30) @(posedge sys_clk);
        chk(32'h0, 32'(irqCnt - irq0));
        i_far.setPin(1'b1);
        repeat (10) @(posedge sys_clk);
        chk(32'h1, 32'(irqCnt - irq0));
        xfer(1'b0, 12'h008, 32'h0);
        chk(32'h1, {31'h0, q >= 58 && q <= 62});
        // Overflow before any result
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b1, 12'h004, 32'hD);
        xfer(1'b1, 12'h000, 32'h1);
        irq0 = irqCnt;
        i_far.setPin(1'b0);
        waitIrq(70000);
        chk(32'h1, 32'(irqCnt - irq0));
        rdChk(12'h008, 32'h0);
        rdChk(12'h000, 32'h0);
        stop_test();
    end
endmodule : tb_oneshot_measure_timer16
